/* hdl/bit_accumulator_load_and_unit.sv */
// Purpose: Executes single-bit load and AND instructions on a
//          one-bit accumulator
// Assumes: Register files answer reads in the same cycle (combinational)
// Notes:   One instruction per cycle while instr_valid is high.
//          Read addresses leave combinationally, a deliberate exception
//          to registered outputs: the answer must land in one cycle.
//          A refused instruction pulses operand_error and leaves the
//          accumulator alone, so a bad program cannot corrupt state.
//          Only the operand field that the form uses is range checked.
//          Reset clears the accumulator; the next edge may take work.
// How it works
// - Constant load writes the immediate bit into the accumulator.
// - Device bit load copies the indexed bit of the addressed register.
// - Scratch bit load copies the indexed bit of a scratch register.
// - Retained bit load copies the indexed bit of a retained register.
// - Inverted device bit load stores the complemented register bit.
// - Inverted scratch bit load stores the complemented scratch bit.
// - Inverted retained bit load stores the complemented retained bit.
// - Device bit AND leaves one only when both accumulator and bit are one.
`timescale 1ns/100ps
module bit_accumulator_load_and_unit #(
  parameter int REG_W = bitacc_pkg::REG_WIDTH
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset,
  // Instruction stream
  input  wire logic                 instr_valid,
  input  wire bitacc_pkg::instr_t   instr,
  // Register file read data
  input  wire logic [REG_W-1:0]     device_reg_data,
  input  wire logic [REG_W-1:0]     scratch_reg_data,
  input  wire logic [REG_W-1:0]     retained_reg_data,
  // Register file read addresses
  output bitacc_pkg::read_addr_t    read_addr,
  // Results
  output logic                      accumulator,
  output logic                      instr_done,
  output logic                      operand_error
);

  // Address spans reachable by each operand field; each must exceed
  // the legal maximum of its range
  localparam int DEV_SPAN      = 1 << bitacc_pkg::DEV_ADDR_W;
  localparam int SCRATCH_SPAN  = 1 << bitacc_pkg::SCRATCH_W;
  localparam int RETAINED_SPAN = 1 << bitacc_pkg::RETAINED_W;
  localparam int INDEX_SPAN    = 1 << bitacc_pkg::BIT_INDEX_W;

  // Elaboration checks: refuse sizes that the logic below cannot serve
  if (REG_W != bitacc_pkg::REG_WIDTH) begin : g_width_check
    $error("bit_accumulator_load_and_unit: register width unsupported");
  end

  // A bit index must reach every bit of a register word
  if (INDEX_SPAN < REG_W) begin : g_index_check
    $error("bit_accumulator_load_and_unit: bit index too narrow");
  end

  // Each operand field must cover its whole legal range
  if (DEV_SPAN <= bitacc_pkg::DEV_ADDR_MAX) begin : g_dev_check
    $error("bit_accumulator_load_and_unit: device address too narrow");
  end

  if (SCRATCH_SPAN <= bitacc_pkg::SCRATCH_MAX) begin : g_scratch_check
    $error("bit_accumulator_load_and_unit: scratch index too narrow");
  end

  if (RETAINED_SPAN <= bitacc_pkg::RETAINED_MAX) begin : g_retained_check
    $error("bit_accumulator_load_and_unit: retained index too narrow");
  end

  // Eight instruction forms need at least three opcode bits; wider
  // codes above the eighth form are refused at run time
  if (bitacc_pkg::OPCODE_W < 3) begin : g_opcode_check
    $error("bit_accumulator_load_and_unit: opcode field too narrow");
  end

  // Registered state and its combinational next values
  logic                 acc_reg;
  logic                 acc_next;
  logic                 done_reg;
  logic                 err_reg;
  logic                 err_next;

  // Decoded opcode, one named wire per instruction form
  wire bitacc_pkg::opcode_t op = bitacc_pkg::opcode_t'(instr.opcode);
  wire logic dec_load_imm = (op == bitacc_pkg::OP_LOAD_IMMEDIATE);
  wire logic dec_load_dev = (op == bitacc_pkg::OP_LOAD_DEVICE_BIT);
  wire logic dec_load_scr = (op == bitacc_pkg::OP_LOAD_SCRATCH_BIT);
  wire logic dec_load_ret = (op == bitacc_pkg::OP_LOAD_RETAINED_BIT);
  wire logic dec_inv_dev  = (op == bitacc_pkg::OP_LOAD_INV_DEVICE_BIT);
  wire logic dec_inv_scr  = (op == bitacc_pkg::OP_LOAD_INV_SCRATCH_BIT);
  wire logic dec_inv_ret  = (op == bitacc_pkg::OP_LOAD_INV_RETAINED_BIT);
  wire logic dec_and_dev  = (op == bitacc_pkg::OP_AND_DEVICE_BIT);

  // Which register file each form reads
  wire logic is_dev_src  = dec_load_dev || dec_inv_dev || dec_and_dev;
  wire logic is_scr_src  = dec_load_scr || dec_inv_scr;
  wire logic is_ret_src  = dec_load_ret || dec_inv_ret;
  // Any code outside the eight forms is refused
  wire logic known_op    = dec_load_imm || is_dev_src || is_scr_src ||
                           is_ret_src;

  // Operand range checks; stale values in fields that the form does
  // not use never cause a refusal
  wire logic dev_range_bad = is_dev_src && (int'(instr.device_reg_address)
                                            > bitacc_pkg::DEV_ADDR_MAX);
  wire logic scr_range_bad = is_scr_src && (int'(instr.scratch_reg_index)
                                            > bitacc_pkg::SCRATCH_MAX);
  wire logic ret_range_bad = is_ret_src && (int'(instr.retained_reg_index)
                                            > bitacc_pkg::RETAINED_MAX);
  wire logic bad_operand = !known_op || dev_range_bad || scr_range_bad ||
                           ret_range_bad;

  // Invert flag for the inverted load forms
  wire logic inv_dev = (op == bitacc_pkg::OP_LOAD_INV_DEVICE_BIT);
  wire logic inv_scr = (op == bitacc_pkg::OP_LOAD_INV_SCRATCH_BIT);
  wire logic inv_ret = (op == bitacc_pkg::OP_LOAD_INV_RETAINED_BIT);

  // Read addresses go straight to the register files this cycle;
  // registering them would cost a cycle on every instruction
  assign read_addr.device_reg_address = instr.device_reg_address;
  assign read_addr.scratch_reg_index  = instr.scratch_reg_index;
  assign read_addr.retained_reg_index = instr.retained_reg_index;

  // One bit picker per register file. All three share the bit index;
  // only the picker of an inverted form has its invert flag set, so
  // the selection below stays a plain copy for every load form
  logic dev_bit;
  logic scr_bit;
  logic ret_bit;

  bit_select #(.WIDTH(REG_W), .IDX_W(bitacc_pkg::BIT_INDEX_W)) u_dev_sel (
    .word   (device_reg_data),
    .index  (instr.bit_index),
    .invert (inv_dev),
    .picked (dev_bit)
  );

  bit_select #(.WIDTH(REG_W), .IDX_W(bitacc_pkg::BIT_INDEX_W)) u_scr_sel (
    .word   (scratch_reg_data),
    .index  (instr.bit_index),
    .invert (inv_scr),
    .picked (scr_bit)
  );

  bit_select #(.WIDTH(REG_W), .IDX_W(bitacc_pkg::BIT_INDEX_W)) u_ret_sel (
    .word   (retained_reg_data),
    .index  (instr.bit_index),
    .invert (inv_ret),
    .picked (ret_bit)
  );

  // Next accumulator value; a rejected instruction leaves it untouched
  // so a bad program cannot corrupt later logic
  always_comb begin
    acc_next = acc_reg;
    err_next = 1'b0;
    if (instr_valid) begin
      err_next = bad_operand;
      if (!bad_operand) begin
        unique case (op)
          bitacc_pkg::OP_LOAD_IMMEDIATE:
            acc_next = instr.immediate_bit;
          bitacc_pkg::OP_LOAD_DEVICE_BIT:
            acc_next = dev_bit;
          bitacc_pkg::OP_LOAD_SCRATCH_BIT:
            acc_next = scr_bit;
          bitacc_pkg::OP_LOAD_RETAINED_BIT:
            acc_next = ret_bit;
          bitacc_pkg::OP_LOAD_INV_DEVICE_BIT:
            acc_next = dev_bit;
          bitacc_pkg::OP_LOAD_INV_SCRATCH_BIT:
            acc_next = scr_bit;
          bitacc_pkg::OP_LOAD_INV_RETAINED_BIT:
            acc_next = ret_bit;
          bitacc_pkg::OP_AND_DEVICE_BIT:
            acc_next = acc_reg & dev_bit;
          default:
            acc_next = acc_reg;
        endcase
      end
    end
  end

  // Accumulator register; reset clears it so that an AND issued right
  // after reset sees a known zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      acc_reg <= bitacc_pkg::ACC_RESET;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // Completion pulse, one cycle after every valid instruction,
  // refused ones included, so the sequencer never waits forever
  always_ff @(posedge mclk) begin
    if (reset) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= instr_valid;
    end
  end

  // Refusal pulse, high together with the completion pulse
  // of the refused instruction and never on its own
  always_ff @(posedge mclk) begin
    if (reset) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= err_next;
    end
  end

  // Registered outputs; every result leaves straight from a flop
  // so downstream timing sees no decode logic
  assign accumulator   = acc_reg;
  assign instr_done    = done_reg;
  assign operand_error = err_reg;

endmodule

/* include/bitacc_pkg.sv */
// Purpose: Shared constants and carriers for the bit accumulator unit
// Assumes: One clock, synchronous active-high reset
// Notes:   Opcode values are local encodings of the instruction set
package bitacc_pkg;

  // Operand space sizes
  localparam int DEV_ADDR_MAX     = 9249;
  localparam int SCRATCH_MAX      = 299;
  localparam int RETAINED_MAX     = 63;
  localparam int REG_WIDTH        = 16;
  localparam int DEV_ADDR_W       = 14;
  localparam int SCRATCH_W        = 9;
  localparam int RETAINED_W       = 6;
  localparam int BIT_INDEX_W      = 4;
  localparam int OPCODE_W         = 4;

  // Reset values
  localparam logic ACC_RESET      = 1'h0;

  // Instruction opcodes
  typedef enum logic [OPCODE_W-1:0] {
    OP_LOAD_IMMEDIATE          = 4'h0,
    OP_LOAD_DEVICE_BIT         = 4'h1,
    OP_LOAD_SCRATCH_BIT        = 4'h2,
    OP_LOAD_RETAINED_BIT       = 4'h3,
    OP_LOAD_INV_DEVICE_BIT     = 4'h4,
    OP_LOAD_INV_SCRATCH_BIT    = 4'h5,
    OP_LOAD_INV_RETAINED_BIT   = 4'h6,
    OP_AND_DEVICE_BIT          = 4'h7
  } opcode_t;

  // One instruction as issued by the program sequencer
  typedef struct packed {
    logic [OPCODE_W-1:0]    opcode;
    logic                   immediate_bit;
    logic [DEV_ADDR_W-1:0]  device_reg_address;
    logic [SCRATCH_W-1:0]   scratch_reg_index;
    logic [RETAINED_W-1:0]  retained_reg_index;
    logic [BIT_INDEX_W-1:0] bit_index;
  } instr_t;

  // Read requests toward the three register files
  typedef struct packed {
    logic [DEV_ADDR_W-1:0]  device_reg_address;
    logic [SCRATCH_W-1:0]   scratch_reg_index;
    logic [RETAINED_W-1:0]  retained_reg_index;
  } read_addr_t;

endpackage

/* hdl/bit_select.sv */
// Purpose: Pick one bit of a register word, optionally inverted
// Assumes: Index within the word width
// Notes:   Pure combinational, one copy per register file
`timescale 1ns/100ps
module bit_select #(
  parameter int WIDTH = 16,
  parameter int IDX_W = 4
) (
  // Word and selection
  input  wire logic [WIDTH-1:0] word,
  input  wire logic [IDX_W-1:0] index,
  input  wire logic             invert,
  // Result
  output logic                  picked
);

  // Elaboration check: the index must reach every bit of the word
  if ((1 << IDX_W) < WIDTH) begin : g_idx_check
    $error("bit_select: index too narrow for word");
  end

  // Selected bit, flipped when asked
  assign picked = word[index] ^ invert;

endmodule

/* tb/bit_acc_props.sv */
// Purpose: Port checker for the bit accumulator unit
// Assumes: Register data are valid in the instruction cycle
// Notes:   Bound from the bench top file
`timescale 1ns/100ps
module bit_acc_props #(
  parameter int REG_W = 16
) (
  // Clock, reset, stream
  input wire logic                   mclk,
  input wire logic                   reset,
  input wire logic                   instr_valid,
  input wire bitacc_pkg::instr_t     instr,
  // Register files
  input wire logic [REG_W-1:0]       device_reg_data,
  input wire logic [REG_W-1:0]       scratch_reg_data,
  input wire logic [REG_W-1:0]       retained_reg_data,
  input wire bitacc_pkg::read_addr_t read_addr,
  // Results
  input wire logic                   accumulator,
  input wire logic                   instr_done,
  input wire logic                   operand_error
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Opcode, range flags and selected bits
  wire [3:0] op  = instr.opcode;
  wire       v   = instr_valid;
  wire       dok = instr.device_reg_address <= 14'h2421;
  wire       sok = instr.scratch_reg_index <= 9'h12B;
  wire       db  = device_reg_data[instr.bit_index];
  wire       sb  = scratch_reg_data[instr.bit_index];
  wire       rb  = retained_reg_data[instr.bit_index];
  wire       bad = op > 4'h7 || (!dok && (op == 4'h1 || op == 4'h4 ||
    op == 4'h7)) || (!sok && (op == 4'h2 || op == 4'h5));
  imm_load_a: assert property (v && op == 4'h0 |=>
    accumulator == $past(instr.immediate_bit)) else $error("imm load");
  dev_load_a: assert property (v && op == 4'h1 && dok |=>
    accumulator == $past(db)) else $error("device load");
  scr_load_a: assert property (v && op == 4'h2 && sok |=>
    accumulator == $past(sb)) else $error("scratch load");
  ret_load_a: assert property (v && op == 4'h3 |=>
    accumulator == $past(rb)) else $error("retained load");
  inv_dev_a: assert property (v && op == 4'h4 && dok |=>
    accumulator != $past(db)) else $error("inverted device load");
  inv_scr_a: assert property (v && op == 4'h5 && sok |=>
    accumulator != $past(sb)) else $error("inverted scratch load");
  inv_ret_a: assert property (v && op == 4'h6 |=>
    accumulator != $past(rb)) else $error("inverted retained load");
  dev_and_a: assert property (v && op == 4'h7 && dok |=>
    accumulator == ($past(accumulator) & $past(db))) else $error("and");
  acc_hold_a: assert property (!v ##1 1'b1 |->
    !instr_done && $stable(accumulator)) else $error("hold");
  refuse_a: assert property (v && bad |=>
    operand_error && $stable(accumulator)) else $error("refused operand");
  done_pulse_a: assert property (v && !bad |=>
    instr_done && !operand_error) else $error("done pulse");
  // Main scenarios
  cover property (v && op == 4'h7 && dok ##1 accumulator);
  cover property (v && op == 4'h5 && sok ##1 instr_done);
  cover property (operand_error);
endmodule

/* tb/reg_files_model.sv */
// Purpose: Same-cycle model of the three register files
// Assumes: Contents are a scramble of address and salt
// Notes:   Salt changes per instruction so contents vary
`timescale 1ns/100ps
module reg_files_model (
  // Read request and content variation
  input  wire bitacc_pkg::read_addr_t read_addr,
  input  wire logic [15:0]            salt,
  // Read data
  output logic [15:0]                 device_reg_data,
  output logic [15:0]                 scratch_reg_data,
  output logic [15:0]                 retained_reg_data
);
  // Combinational answers, as the unit reads in the same cycle
  assign device_reg_data   = {2'h0, read_addr.device_reg_address} ^ salt;
  assign scratch_reg_data  = {7'h00, read_addr.scratch_reg_index} ^ salt;
  assign retained_reg_data = {10'h000, read_addr.retained_reg_index} ^ salt;
endmodule

/* tb/bit_accumulator_load_and_unit_tb_top.sv */
// Purpose: Self-checking bench for the bit accumulator unit
// Assumes: Register file model scrambles address with salt
// Notes:   LFSR stream plus operand range boundaries
`timescale 1ns/100ps
module bit_accumulator_load_and_unit_tb_top;
  logic                   mclk = 1'b0;
  logic                   reset = 1'b1;
  logic                   instr_valid = 1'b0;
  bitacc_pkg::instr_t     instr = '0;
  logic [15:0]            salt = 16'h0000;
  logic [15:0]            dev_d, scr_d, ret_d;
  bitacc_pkg::read_addr_t read_addr;
  logic                   accumulator, instr_done, operand_error;
  logic [31:0]            r = 32'h01C27EB1;
  int                     errors = 0;
  int                     checks_done = 0;
  int                     m_acc = 0;
  // 125 MHz clock
  always #4 mclk = ~mclk;
  reg_files_model regs (.read_addr(read_addr), .salt(salt),
    .device_reg_data(dev_d), .scratch_reg_data(scr_d),
    .retained_reg_data(ret_d));
  bit_accumulator_load_and_unit DUT (.mclk(mclk), .reset(reset),
    .instr_valid(instr_valid), .instr(instr), .device_reg_data(dev_d),
    .scratch_reg_data(scr_d), .retained_reg_data(ret_d),
    .read_addr(read_addr), .accumulator(accumulator),
    .instr_done(instr_done), .operand_error(operand_error));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One cycle: drive, step the model, compare after the edge
  task automatic issue(input logic v, input bitacc_pkg::instr_t i,
                       input logic [15:0] s);
    int bi, n, err;
    int w[3];
    bi = i.bit_index;
    w[0] = ((i.device_reg_address ^ s) >> bi) & 1;
    w[1] = ((i.scratch_reg_index ^ s) >> bi) & 1;
    w[2] = ((i.retained_reg_index ^ s) >> bi) & 1;
    err = i.opcode > 7 || (i.opcode inside {1, 4, 7}
      && i.device_reg_address > 9249)
      || (i.opcode inside {2, 5} && i.scratch_reg_index > 299);
    case (i.opcode)
      0: n = i.immediate_bit;
      1, 2, 3: n = w[i.opcode - 1];
      4, 5, 6: n = 1 - w[i.opcode - 4];
      7: n = m_acc & w[0];
      default: n = m_acc;
    endcase
    instr_valid = v;
    instr = i;
    salt = s;
    @(posedge mclk);
    #1;
    if (v && !err) m_acc = n;
    if (!v || err) check(accumulator, m_acc[0]);
    else if (i.opcode < 3) check(accumulator, m_acc[0]);
    else if (i.opcode < 6) check(accumulator, m_acc[0]);
    else check(accumulator, m_acc[0]);
    check(instr_done, v);
    check(operand_error, v && err);
  endtask
  initial begin
    bitacc_pkg::instr_t i;
    repeat (8) @(posedge mclk);
    #1 reset = 1'b0;
    // Last legal and first refused operand of the device and scratch ranges
    for (int k = 0; k < 4; k++) begin
      i = '0;
      i.bit_index = 4'hF;
      i.opcode = k[1] ? 4'h2 : 4'h1;
      i.device_reg_address = 14'h2421 + 14'(k[0]);
      i.scratch_reg_index = 9'h12B + 9'(k[0]);
      issue(1'b1, i, 16'hFFFF);
    end
    // Random stream with idle gaps and one reset in mid-run
    for (int k = 0; k < 400; k++) begin
      r = lfsr(r);
      i = {r, r[31:26]};
      i.opcode[3] = i.opcode[3] & r[7] & r[9];
      if (k == 200) begin
        instr_valid = 1'b0;
        reset = 1'b1;
        repeat (2) @(posedge mclk);
        #1 reset = 1'b0;
        m_acc = 0;
        check(accumulator, 1'b0);
        check(instr_done, 1'b0);
        check(operand_error, 1'b0);
      end
      issue(r[12] | r[13], i, r[31:16] ^ r[15:0]);
    end
    end_sim();
  end
  // About 420 cycles expected; a hang is cut at 2000
  initial begin
    #16000;
    errors++;
    end_sim();
  end
endmodule
bind bit_accumulator_load_and_unit bit_acc_props #(.REG_W(REG_W)) props (
  .mclk(mclk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
  .device_reg_data(device_reg_data), .scratch_reg_data(scratch_reg_data),
  .retained_reg_data(retained_reg_data), .read_addr(read_addr),
  .accumulator(accumulator), .instr_done(instr_done),
  .operand_error(operand_error));
